// ===== afe_params.svh
/*
  constants for the front-end reset and clock control block: register offsets,
  control-port address, timing counts.
  assumes a single 40 MHz system clock.
*/
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH
`define AFE_CLK_MHZ          40
`define AFE_POR_TIME_US      4000
`define AFE_POR_CYCLES       (`AFE_POR_TIME_US * `AFE_CLK_MHZ)
`define AFE_SPIKE_TIME_NS    50
`define AFE_SPIKE_CYCLES     ((`AFE_SPIKE_TIME_NS * `AFE_CLK_MHZ + 999) / 1000)
`define AFE_DEV_ADDR_W       8'h90
`define AFE_REG_PAGE         8'h00
`define AFE_REG_RUN          8'h02
`define AFE_REG_BOOK         8'h7f
`define AFE_RUN_ENABLE_VAL   8'h00
`define AFE_RUN_RESET_VAL    8'h10
`define AFE_OSR_FACTOR       128
`define AFE_SCL_HALF         8'd50
`define AFE_HR_CMD           8'h00
`define AFE_HR_STAT          8'h04
`define AFE_HR_IRQ_STAT      8'h08
`define AFE_HR_IRQ_MASK      8'h0c
`define AFE_HR_CFG           8'h10
`define AFE_CMD_GO_BIT       8
`define AFE_CFG_DACSRC_BIT   0
`define AFE_CFG_PLLREF_BIT   1
`define AFE_CFG_SDOPOST_BIT  2
`endif

// ===== afe_pkg.sv
/*
  shared types of the front-end control block.
  assumes afe_params.svh is compiled alongside.
*/
package afe_pkg;
  typedef enum logic [1:0] {
    AFE_POR_OFF  = 2'b00,
    AFE_POR_WAIT = 2'b01,
    AFE_POR_RUN  = 2'b10
  } afe_por_t;
  typedef enum logic [2:0] {
    AFE_I2C_IDLE = 3'b000,
    AFE_I2C_ADDR = 3'b001,
    AFE_I2C_ACK  = 3'b010,
    AFE_I2C_DATA = 3'b011,
    AFE_I2C_SKIP = 3'b100
  } afe_i2c_t;
endpackage

// ===== afe_link_if.sv
/*
  control-port and audio-clock link between the host end and the device end.
  resolves open-drain levels here from the enables; no line drives high.
*/
`timescale 1ns/10ps
interface afe_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  logic mclk;
  logic bclk;
  logic word_frame_clock;
  logic fault_n;
  assign scl = ~scl_oe;
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport host (output scl_o, output scl_oe, output sda_host_oe, input scl, input sda,
                input fault_n);
  modport dev  (input scl, input sda, output sda_dev_oe, input mclk, input bclk,
                input word_frame_clock, output fault_n);
endinterface

// ===== afe_dev.sv
/*
  device end: power-on reset hold, control-port slave, book/page/run registers,
  clock source selection and fault pin.
  assumes audio clocks and control lines are sampled synchronously to i_clock.
*/
// The strobed register port is this design's own decision.
// Function
// - hold registers at default until clocks toggle 4ms
// - then release reset, accept control writes
// - host writes run register zero to enable
// - offset 00 selects the register page
// - offset 7f on page 0 selects book
// - control only via I2C, address byte 90
// - samples interpolated to 128 times sample rate
// - internal clocks derived from serial audio clocks
// - PLL reference is master or bit clock
// - host should pick master clock for DAC
// - serial data out carries pre or post data
// - fault pin flags amplifier faults
// - control inputs suppress glitches up to 50ns
`timescale 1ns/10ps
`include "afe_params.svh"
module afe_dev #(
  parameter int POR_CYCLES = `AFE_POR_CYCLES
) (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  afe_link_if.dev          link,
  input  wire logic        i_supply_ok,
  input  wire logic        i_fault_event,
  input  wire logic        i_pre_data,
  input  wire logic        i_post_data,
  output logic             o_serial_data_out,
  output logic             o_regs_ready,
  output logic [7:0]       o_page,
  output logic [7:0]       o_book,
  output logic             o_running,
  output logic             o_dac_from_mclk,
  output logic             o_pll_ref_bclk,
  output logic [7:0]       o_osr_factor
);
  afe_pkg::afe_por_t por_q;
  afe_pkg::afe_i2c_t st_q;
  logic [31:0] por_cnt_q;
  logic [2:0]  mclk_h_q, bclk_h_q, wck_h_q;
  logic        toggling;
  logic        scl_q, sda_q, scl_p_q, sda_p_q;
  logic [3:0]  scl_cnt_q, sda_cnt_q;
  logic [7:0]  sh_q;
  logic [3:0]  bit_q;
  logic [1:0]  byte_q;
  logic [7:0]  ptr_q;
  logic [7:0]  page_q, book_q, run_q, clk_cfg_q;
  logic        ack_q;
  logic        start, stop, rise, fall;

  function automatic logic edge3(input logic [2:0] h);
    return h[2] ^ h[1];
  endfunction

  always_ff @(posedge i_clock) begin
    mclk_h_q <= {mclk_h_q[1:0], link.mclk};
    bclk_h_q <= {bclk_h_q[1:0], link.bclk};
    wck_h_q  <= {wck_h_q[1:0], link.word_frame_clock};
  end
  assign toggling = edge3(mclk_h_q) | edge3(bclk_h_q) | edge3(wck_h_q);

  // only cycles with a moving audio clock count; a stall pauses the count, not restarts it
  always_ff @(posedge i_clock) begin
    if (i_srst || !i_supply_ok) begin
      por_q     <= afe_pkg::AFE_POR_OFF;
      por_cnt_q <= 32'h0;
    end else begin
      case (por_q)
        afe_pkg::AFE_POR_OFF: por_q <= afe_pkg::AFE_POR_WAIT;
        afe_pkg::AFE_POR_WAIT: begin
          if (toggling) begin
            por_cnt_q <= por_cnt_q + 32'h1;
          end
          if (por_cnt_q >= POR_CYCLES) begin
            por_q <= afe_pkg::AFE_POR_RUN;
          end
        end
        afe_pkg::AFE_POR_RUN: por_q <= afe_pkg::AFE_POR_RUN;
        default: por_q <= afe_pkg::AFE_POR_OFF;
      endcase
    end
  end
  assign o_regs_ready = (por_q == afe_pkg::AFE_POR_RUN);

  // a level must hold longer than this many cycles before it is believed
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_cnt_q <= 4'h0;
      sda_cnt_q <= 4'h0;
    end else begin
      if (link.scl == scl_q) begin
        scl_cnt_q <= 4'h0;
      end else if (scl_cnt_q >= 4'(`AFE_SPIKE_CYCLES)) begin
        scl_q <= link.scl;
        scl_cnt_q <= 4'h0;
      end else begin
        scl_cnt_q <= scl_cnt_q + 4'h1;
      end
      if (link.sda == sda_q) begin
        sda_cnt_q <= 4'h0;
      end else if (sda_cnt_q >= 4'(`AFE_SPIKE_CYCLES)) begin
        sda_q <= link.sda;
        sda_cnt_q <= 4'h0;
      end else begin
        sda_cnt_q <= sda_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    scl_p_q <= scl_q;
    sda_p_q <= sda_q;
  end
  assign start = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign stop  = scl_q & scl_p_q & ~sda_p_q & sda_q;
  assign rise  = scl_q & ~scl_p_q;
  assign fall  = ~scl_q & scl_p_q;

  // write-only slave; reads are not acknowledged
  // supply loss clears the registers at the very edge that drops ready
  always_ff @(posedge i_clock) begin
    if (i_srst || !i_supply_ok || !o_regs_ready) begin
      st_q <= afe_pkg::AFE_I2C_IDLE;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h0;
      ack_q <= 1'b0;
      ptr_q <= 8'h0;
      page_q <= `AFE_REG_PAGE;
      book_q <= 8'h00;
      run_q <= `AFE_RUN_RESET_VAL;
      clk_cfg_q <= 8'h00;
    end else if (start) begin
      st_q <= afe_pkg::AFE_I2C_ADDR;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
    end else if (stop) begin
      st_q <= afe_pkg::AFE_I2C_IDLE;
      ack_q <= 1'b0;
    end else begin
      case (st_q)
        afe_pkg::AFE_I2C_IDLE: st_q <= afe_pkg::AFE_I2C_IDLE;
        afe_pkg::AFE_I2C_ADDR, afe_pkg::AFE_I2C_DATA: begin
          if (rise) begin
            sh_q <= {sh_q[6:0], sda_q};
            bit_q <= bit_q + 4'h1;
          end
          if (fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (st_q == afe_pkg::AFE_I2C_ADDR) begin
              ack_q <= (sh_q == `AFE_DEV_ADDR_W);
              st_q <= (sh_q == `AFE_DEV_ADDR_W) ? afe_pkg::AFE_I2C_ACK
                                                : afe_pkg::AFE_I2C_SKIP;
            end else begin
              ack_q <= 1'b1;
              st_q <= afe_pkg::AFE_I2C_ACK;
              if (byte_q == 2'h1) begin
                ptr_q <= sh_q;
              end else begin
                ptr_q <= ptr_q + 8'h1;
                if (ptr_q == `AFE_REG_PAGE) begin
                  page_q <= sh_q;
                end else if (ptr_q == `AFE_REG_BOOK && page_q == 8'h00) begin
                  book_q <= sh_q;
                end else if (book_q == 8'h00 && page_q == 8'h00) begin
                  if (ptr_q == `AFE_REG_RUN) begin
                    run_q <= sh_q;
                  end else if (ptr_q == 8'h0d) begin
                    clk_cfg_q <= sh_q;
                  end
                end
              end
            end
          end
        end
        afe_pkg::AFE_I2C_ACK: begin
          if (fall) begin
            ack_q <= 1'b0;
            byte_q <= (byte_q == 2'h2) ? 2'h2 : byte_q + 2'h1;
            st_q <= afe_pkg::AFE_I2C_DATA;
          end
        end
        afe_pkg::AFE_I2C_SKIP: st_q <= afe_pkg::AFE_I2C_SKIP;
        default: st_q <= afe_pkg::AFE_I2C_IDLE;
      endcase
    end
  end
  assign link.sda_dev_oe = ack_q;

  // outputs of the clock tree and data path
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_serial_data_out <= 1'b0;
    end else begin
      o_serial_data_out <= clk_cfg_q[`AFE_CFG_SDOPOST_BIT] ? i_post_data : i_pre_data;
    end
  end
  assign o_page = page_q;
  assign o_book = book_q;
  assign o_running = o_regs_ready && run_q == `AFE_RUN_ENABLE_VAL;
  assign o_dac_from_mclk = clk_cfg_q[`AFE_CFG_DACSRC_BIT];
  assign o_pll_ref_bclk = clk_cfg_q[`AFE_CFG_PLLREF_BIT];
  assign o_osr_factor = 8'(`AFE_OSR_FACTOR);
  assign link.fault_n = ~i_fault_event;
endmodule

// ===== afe_host.sv
/*
  host end: register-port controller that issues control-port writes
  (address byte, register, value) and reports status and interrupts.
  assumes one 40 MHz clock and a device answering on the shared link.
*/
`timescale 1ns/10ps
`include "afe_params.svh"
module afe_host (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  afe_link_if.host         link,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_irq
);
  logic [15:0] cmd_q;
  logic        busy_q, nack_q;
  logic [1:0]  sts_q, msk_q;
  logic [7:0]  div_q;
  logic [5:0]  ph_q;
  logic [26:0] frame_q;
  logic        sda_oe_q, scl_oe_q, done_p, nack_p;
  logic [1:0]  ev;

  // frame: start, 27 bit slots (3 bytes + 3 ack), stop
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      busy_q <= 1'b0;
      ph_q <= 6'h0;
      div_q <= 8'h0;
      frame_q <= 27'h0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (!busy_q) begin
      if (i_wr && i_addr == `AFE_HR_CMD && i_wdata[`AFE_CMD_GO_BIT]) begin
        busy_q <= 1'b1;
        frame_q <= {`AFE_DEV_ADDR_W, 1'b1, cmd_q[15:8], 1'b1, i_wdata[7:0], 1'b1};
        ph_q <= 6'h0;
        div_q <= 8'h0;
        sda_oe_q <= 1'b1;
        nack_q <= 1'b0;
      end
    end else if (div_q != `AFE_SCL_HALF) begin
      div_q <= div_q + 8'h1;
    end else begin
      div_q <= 8'h0;
      ph_q <= ph_q + 6'h1;
      if (ph_q < 6'd54) begin
        scl_oe_q <= ~ph_q[0];
        if (!ph_q[0]) begin
          sda_oe_q <= ~frame_q[26];
        end else begin
          if ((ph_q == 6'd17 || ph_q == 6'd35 || ph_q == 6'd53) && link.sda) begin
            nack_q <= 1'b1;
          end
          frame_q <= {frame_q[25:0], 1'b1};
        end
      end else if (ph_q == 6'd54) begin
        scl_oe_q <= 1'b1;
        sda_oe_q <= 1'b1;
      end else if (ph_q == 6'd55) begin
        scl_oe_q <= 1'b0;
      end else begin
        sda_oe_q <= 1'b0;
        busy_q <= 1'b0;
      end
    end
  end
  assign done_p = busy_q && ph_q == 6'd56 && div_q == `AFE_SCL_HALF;
  assign nack_p = done_p && nack_q;
  assign link.scl_o = ~scl_oe_q;
  assign link.scl_oe = scl_oe_q;
  assign link.sda_host_oe = sda_oe_q;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cmd_q <= 16'h0;
      msk_q <= 2'h0;
    end else if (i_wr && i_addr == `AFE_HR_CFG) begin
      cmd_q <= {i_wdata[7:0], 8'h00};
    end else if (i_wr && i_addr == `AFE_HR_IRQ_MASK) begin
      msk_q <= i_wdata[1:0];
    end
  end

  // set wins over a clear in the same cycle
  assign ev = {~link.fault_n, done_p};
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sts_q <= 2'h0;
    end else begin
      sts_q <= (sts_q & ~((i_wr && i_addr == `AFE_HR_IRQ_STAT) ? i_wdata[1:0] : 2'h0)) | ev;
    end
  end
  assign o_irq = |(sts_q & msk_q);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      case (i_addr)
        `AFE_HR_CMD:      o_rdata <= {24'h0, cmd_q[15:8]};
        `AFE_HR_STAT:     o_rdata <= {29'h0, ~link.fault_n, nack_q, busy_q};
        `AFE_HR_IRQ_STAT: o_rdata <= {30'h0, sts_q};
        `AFE_HR_IRQ_MASK: o_rdata <= {30'h0, msk_q};
        default:          o_rdata <= 32'h0;
      endcase
    end else begin
      o_rdata <= 32'h0;
    end
  end
endmodule

// ===== afe_link_assertions.sv
/* checker for the link and device status of the front-end control block.
   assumes it is instantiated beside the link in the testbench, one clock. */
`timescale 1ns/10ps
`include "afe_params.svh"
module afe_link_assertions #(
  parameter int POR_CYCLES = `AFE_POR_CYCLES
) (
  input wire logic       i_clock,
  input wire logic       i_srst,
  input wire logic       scl,
  input wire logic       sda_dev_oe,
  input wire logic       fault_n,
  input wire logic       mclk,
  input wire logic       bclk,
  input wire logic       word_frame_clock,
  input wire logic       i_supply_ok,
  input wire logic       i_fault_event,
  input wire logic       o_regs_ready,
  input wire logic [7:0] o_page,
  input wire logic [7:0] o_book,
  input wire logic       o_running,
  input wire logic [7:0] o_osr_factor
);
  // counts cycles with any audio clock moving; a few cycles of slack for input syncing
  int unsigned tog_q;
  logic [2:0]  clk_q;
  always_ff @(posedge i_clock) begin
    clk_q <= {mclk, bclk, word_frame_clock};
    if (i_srst || !i_supply_ok) begin
      tog_q <= 0;
    end else if (clk_q != {mclk, bclk, word_frame_clock}) begin
      tog_q <= tog_q + 1;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  AST_HOLD_DEFAULTS: assert property (!o_regs_ready |-> o_page == 8'h00 && o_book == 8'h00
    && !o_running) else $error("registers left default before ready");
  AST_READY_AFTER_TOGGLE: assert property ($rose(o_regs_ready) |-> tog_q >= POR_CYCLES - 3)
    else $error("ready before clocks toggled long enough");
  AST_NO_ACK_EARLY: assert property (!o_regs_ready |-> !sda_dev_oe)
    else $error("acknowledge before ready");
  AST_READY_HELD: assert property (o_regs_ready && i_supply_ok |=> o_regs_ready)
    else $error("ready dropped");
  AST_RUN_BOOK0: assert property ($rose(o_running) |-> o_page == 8'h00 && o_book == 8'h00)
    else $error("run enabled outside book 0 page 0");
  AST_BOOK_PAGE0: assert property ($changed(o_book) |-> $past(o_page) == 8'h00)
    else $error("book changed off page 0");
  AST_ACK_SCL_LOW: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("data line moved while clock high");
  AST_OSR_FIXED: assert property (o_regs_ready |-> o_osr_factor == 8'h80)
    else $error("oversampling factor wrong");
  AST_FAULT_PIN: assert property (i_fault_event |-> !fault_n)
    else $error("fault pin idle during fault");
endmodule

// ===== audio_front_end_reset_clock_ctl_tb.sv
/* self-checking bench: host end and device end joined by the link.
   assumes design files and checker compiled first; audio clocks made here. */
`timescale 1ns/10ps
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module audio_front_end_reset_clock_ctl_tb;
  localparam int POR = 20;
  logic        i_clock = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_supply_ok = 1'b0;
  logic        i_fault_event = 1'b0;
  logic        i_pre_data = 1'b1;
  logic        i_post_data = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata, d, e;
  logic        o_irq, o_serial_data_out, o_regs_ready, o_running, o_dac_from_mclk, o_pll_ref_bclk;
  logic [7:0]  o_page, o_book, o_osr_factor;
  logic [4:0]  ck = 5'h00;
  logic        clk_run = 1'b0;
  int          mismatches = 0;
  int          check_count = 0;
  afe_link_if lk ();
  assign lk.mclk = ck[0];
  assign lk.bclk = ck[1];
  assign lk.word_frame_clock = ck[4];
  afe_host afe_host_i (.i_clock, .i_srst, .link(lk.host), .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_irq);
  afe_dev #(.POR_CYCLES(POR)) afe_dev_i (.i_clock, .i_srst, .link(lk.dev), .i_supply_ok,
    .i_fault_event, .i_pre_data, .i_post_data, .o_serial_data_out, .o_regs_ready, .o_page,
    .o_book, .o_running, .o_dac_from_mclk, .o_pll_ref_bclk, .o_osr_factor);
  afe_link_assertions #(.POR_CYCLES(POR)) afe_link_assertions_i (.i_clock, .i_srst,
    .scl(lk.scl), .sda_dev_oe(lk.sda_dev_oe), .fault_n(lk.fault_n), .mclk(lk.mclk),
    .bclk(lk.bclk), .word_frame_clock(lk.word_frame_clock), .i_supply_ok, .i_fault_event,
    .o_regs_ready, .o_page, .o_book, .o_running, .o_osr_factor);
  initial forever #12.5 i_clock = ~i_clock;
  // audio clocks stand still until the power-on test starts them
  always @(posedge i_clock) if (clk_run) ck <= ck + 5'h01;
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 q = o_rdata;
  endtask
  // one control frame: offset then value; done bit polled, then cleared
  task automatic xfer(input logic [7:0] off, input logic [7:0] val);
    d = 32'h0;
    wr(8'h10, {24'h0, off});
    wr(8'h00, {23'h0, 1'b1, val});
    rd(8'h04, e);
    `CHK(e[0], 1'b1, "busy not shown during frame")
    for (int n = 0; n < 3000 && d[0] !== 1'b1; n++) rd(8'h08, d);
    `CHK(d[0], 1'b1, "frame never done")
    wr(8'h08, 32'h1);
  endtask
  task automatic t_por();
    xfer(8'h00, 8'h05);
    `CHK(o_regs_ready, 1'b0, "ready with idle clocks")
    `CHK(o_page, 8'h00, "write taken before ready")
    rd(8'h04, e);
    `CHK(e[1], 1'b1, "acknowledged before ready")
    @(posedge i_clock);
    clk_run <= 1'b1;
    repeat (POR + 20) @(posedge i_clock);
    `CHK(o_regs_ready, 1'b1, "not ready after toggling")
    $display("power-on test done");
  endtask
  task automatic t_pages();
    xfer(8'h00, 8'h05);
    `CHK(o_page, 8'h05, "page select")
    xfer(8'h7f, 8'h03);
    `CHK(o_book, 8'h00, "book changed off page 0")
    xfer(8'h00, 8'h00);
    xfer(8'h7f, 8'h03);
    `CHK(o_book, 8'h03, "book select")
    `CHK(o_page, 8'h00, "page lost")
    xfer(8'h7f, 8'h00);
    `CHK(o_running, 1'b0, "running out of reset")
    xfer(8'h02, 8'h00);
    `CHK(o_running, 1'b1, "run enable")
    rd(8'h00, e);
    `CHK(e[7:0], 8'h02, "offset readback")
    $display("page and run test done");
  endtask
  task automatic t_clock();
    `CHK(o_osr_factor, 8'h80, "oversampling factor")
    xfer(8'h0d, 8'h03);
    `CHK({o_dac_from_mclk, o_pll_ref_bclk}, 2'b11, "clock select")
    `CHK(o_serial_data_out, i_pre_data, "pre data")
    xfer(8'h0d, 8'h04);
    `CHK({o_dac_from_mclk, o_pll_ref_bclk}, 2'b00, "clock select clear")
    `CHK(o_serial_data_out, i_post_data, "post data")
    $display("clock test done");
  endtask
  task automatic t_fault();
    @(posedge i_clock);
    i_fault_event <= 1'b1;
    repeat (4) @(posedge i_clock);
    `CHK(lk.fault_n, 1'b0, "fault pin")
    rd(8'h04, e);
    `CHK(e[2], 1'b1, "fault status")
    wr(8'h0c, 32'h0);
    repeat (2) @(posedge i_clock);
    d[0] = o_irq;
    wr(8'h0c, 32'h3);
    repeat (2) @(posedge i_clock);
    `CHK(d[0], 1'b0, "interrupt while masked")
    `CHK(o_irq, 1'b1, "mask without effect")
    i_fault_event <= 1'b0;
    repeat (4) @(posedge i_clock);
    wr(8'h08, 32'h3);
    rd(8'h08, e);
    `CHK(e[1:0], 2'b00, "status not cleared")
    `CHK(o_irq, 1'b0, "interrupt after clear")
    $display("fault test done");
  endtask
  // supply dip with clocks running: defaults forced, then a fresh hold period
  task automatic t_supply();
    xfer(8'h00, 8'h05);
    @(posedge i_clock);
    i_supply_ok <= 1'b0;
    repeat (3) @(posedge i_clock);
    `CHK(o_regs_ready, 1'b0, "ready with supply low")
    `CHK(o_page, 8'h00, "page kept over supply loss")
    i_supply_ok <= 1'b1;
    repeat (POR + 20) @(posedge i_clock);
    `CHK(o_regs_ready, 1'b1, "not ready after supply return")
    `CHK(o_running, 1'b0, "run kept over supply loss")
    $display("supply test done");
  endtask
  initial begin
    repeat (12) @(posedge i_clock);
    i_srst <= 1'b0;
    i_supply_ok <= 1'b1;
    t_por();
    t_pages();
    t_clock();
    t_fault();
    t_supply();
    close_out();
  end
  // ten frames of some three thousand cycles each, with margin
  initial begin
    #2250000;
    mismatches++;
    close_out();
  end
endmodule
